// *** rtl/bar_pkg.sv ***
// constants for the bus address relocation block
package bar_pkg;
    localparam int          CPU_AW       = 16;
    localparam int          BUS_AW       = 18;
    localparam int          DW           = 16;
    localparam int          BW           = 8;
    // top three cpu bits that mark the reserved 8k window
    localparam int          TOP_LSB      = 13;
    localparam logic [2:0]  TOP_ONES     = 3'h7;
    localparam logic [1:0]  EXT_ONES     = 2'h3;
    localparam logic [1:0]  EXT_ZERO     = 2'h0;
    localparam logic [17:0] ADDR_RST     = 18'h00000;
    localparam logic [15:0] DATA_RST     = 16'h0000;
    localparam logic [1:0]  BE_RST       = 2'h0;
    localparam logic [1:0]  BE_WORD      = 2'h3;
    localparam logic [1:0]  BE_LOW       = 2'h1;
    localparam logic [1:0]  BE_HIGH      = 2'h2;
endpackage

// *** rtl/bar_lane.sv ***
`timescale 1ns/1ns
// byte lane steering for word and byte accesses
module bar_lane (
    input  wire logic [15:0] cpu_wdata,
    input  wire logic        cpu_byte,
    input  wire logic        addr_odd,
    output logic      [1:0]  lane_be,
    output logic      [15:0] lane_wdata
);
    always_comb begin
        if (!cpu_byte) begin
            lane_be    = bar_pkg::BE_WORD;
            lane_wdata = cpu_wdata;
        end else if (addr_odd) begin
            // odd byte rides the high lane
            lane_be    = bar_pkg::BE_HIGH;
            lane_wdata = {cpu_wdata[7:0], cpu_wdata[7:0]};
        end else begin
            lane_be    = bar_pkg::BE_LOW;
            lane_wdata = {cpu_wdata[7:0], cpu_wdata[7:0]};
        end
    end
endmodule

// *** rtl/bar_master.sv ***
`timescale 1ns/1ns
// bus master address generation with top 8k relocation
// Notes on behaviour
// (R1) word access uses even address, odd is refused
// (R2) byte access picks half by parity
// (R3) bus address is 18 bits wide
// (R4) cpu supplies only 16 address bits
// (R5) top three ones force bits 17:16 high
// (R6) 160000-177777 relocates to 760000-777777
// (R7) lower addresses pass with zero top
// (R8) top 8k holds registers, no memory
// (R9) byte write changes only selected byte
module bar_master (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        cpu_req,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_write,
    input  wire logic        cpu_byte,
    input  wire logic [15:0] cpu_wdata,
    input  wire logic        bus_master,
    output logic             bus_valid,
    output logic      [17:0] bus_addr,
    output logic             bus_write,
    output logic      [1:0]  bus_be,
    output logic      [15:0] bus_wdata,
    output logic             align_err
);
    // one register stage between cpu and bus: every access costs
    // a cycle, but the far side sees an address that never glitches
    // while the relocation logic settles

    // what the request on this edge turns out to be
    typedef enum logic [2:0] {
        BAR_KIND_IDLE = 3'h0,
        BAR_KIND_WORD = 3'h1,
        BAR_KIND_LOW  = 3'h2,
        BAR_KIND_HIGH = 3'h3,
        BAR_KIND_ODD  = 3'h4
    } bar_kind_e;

    typedef struct packed {
        logic        valid;
        logic [17:0] addr;
        logic        write;
        logic [1:0]  be;
        logic [15:0] wdata;
        logic        err;
    } bar_state_s;

    bar_state_s  st_reg;
    bar_state_s  st_next;
    bar_kind_e   kind;
    logic        taken;
    logic        addr_odd;
    logic [17:0] reloc_addr;
    logic [1:0]  lane_be;
    logic [15:0] lane_wdata;

    // (R4) cpu gives 16 bits only; the two upper bus bits are made
    // here, so nothing else can hand memory a stray high address
    function automatic logic [17:0] bar_relocate(
        input logic [15:0] addr
    );
        logic [2:0] top;
        logic [1:0] ext;

        top = addr[15:bar_pkg::TOP_LSB];
        // (R7) low addresses keep zero top
        ext = bar_pkg::EXT_ZERO;
        // (R5) three ones force top
        if (top == bar_pkg::TOP_ONES) begin
            // (R6) window moves to bus top
            ext = bar_pkg::EXT_ONES;
        end
        return {ext, addr};
    endfunction

    // one decode of the request, so the next-state logic
    // only ever looks at a single code
    function automatic bar_kind_e bar_classify(
        input logic req_ok,
        input logic byte_acc,
        input logic odd
    );
        bar_kind_e k;

        k = BAR_KIND_IDLE;
        if (req_ok) begin
            case ({byte_acc, odd})
                2'h0: begin
                    k = BAR_KIND_WORD;
                end
                2'h1: begin
                    // (R1) odd word address refused
                    k = BAR_KIND_ODD;
                end
                2'h2: begin
                    k = BAR_KIND_LOW;
                end
                2'h3: begin
                    // (R2) odd byte is high half
                    k = BAR_KIND_HIGH;
                end
                default: begin
                    k = BAR_KIND_IDLE;
                end
            endcase
        end

        return k;
    endfunction

    // request ignored while another master owns the bus
    assign taken      = cpu_req && bus_master;
    // (R2) parity shared by lanes and decode
    assign addr_odd   = cpu_addr[0];

    assign kind       = bar_classify(taken, cpu_byte, addr_odd);
    // (R3) widened to bus here
    assign reloc_addr = bar_relocate(cpu_addr);

    bar_lane u_lane (
        .cpu_wdata  (cpu_wdata),
        .cpu_byte   (cpu_byte),
        .addr_odd   (addr_odd),
        .lane_be    (lane_be),
        .lane_wdata (lane_wdata)
    );

    // answer lands one edge after the request; valid and err are
    // single pulses, address, direction, lanes and data hold until
    // the next accepted access so a slow device can still look
    always_comb begin
        st_next = st_reg;

        case (kind)
            BAR_KIND_IDLE: begin
                // no request or not bus master: valid and err drop, the rest holds
                st_next.valid = 1'h0;
                st_next.err   = 1'h0;
                st_next.addr  = st_reg.addr;
                st_next.write = st_reg.write;
                st_next.be    = st_reg.be;
                st_next.wdata = st_reg.wdata;
            end

            BAR_KIND_ODD: begin
                // refused rather than rounded, so software sees the slip
                st_next.valid = 1'h0;
                st_next.err   = 1'h1;
                st_next.addr  = st_reg.addr;
                st_next.write = st_reg.write;
                st_next.be    = st_reg.be;
                st_next.wdata = st_reg.wdata;
            end

            BAR_KIND_WORD: begin
                st_next.valid = 1'h1;
                st_next.err   = 1'h0;
                st_next.addr  = reloc_addr;
                st_next.write = cpu_write;
                // (R1) word fills both lanes
                st_next.be    = lane_be;
                st_next.wdata = lane_wdata;
            end

            BAR_KIND_LOW: begin
                st_next.valid = 1'h1;
                st_next.err   = 1'h0;
                st_next.addr  = reloc_addr;
                st_next.write = cpu_write;
                // (R2) even byte, low lane
                st_next.be    = lane_be;
                st_next.wdata = lane_wdata;
            end

            BAR_KIND_HIGH: begin
                st_next.valid = 1'h1;
                st_next.err   = 1'h0;
                st_next.addr  = reloc_addr;
                st_next.write = cpu_write;
                // (R2) odd byte, high lane
                st_next.be    = lane_be;
                // (R9) strobe spares other byte
                st_next.wdata = lane_wdata;
            end

            default: begin
                // unused codes behave as idle
                st_next.valid = 1'h0;
                st_next.err   = 1'h0;
                st_next.addr  = st_reg.addr;
                st_next.write = st_reg.write;
                st_next.be    = st_reg.be;
                st_next.wdata = st_reg.wdata;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg.valid <= 1'h0;
            st_reg.addr  <= bar_pkg::ADDR_RST;
            st_reg.write <= 1'h0;
            st_reg.be    <= bar_pkg::BE_RST;
            st_reg.wdata <= bar_pkg::DATA_RST;
            st_reg.err   <= 1'h0;
        end else begin
            st_reg <= st_next;
        end
    end

    // strobes straight from the register, no gating after it
    assign bus_valid = st_reg.valid;
    assign align_err = st_reg.err;

    // (R3) full 18 bit bus address
    assign bus_addr  = st_reg.addr;

    assign bus_write = st_reg.write;
    assign bus_be    = st_reg.be;
    assign bus_wdata = st_reg.wdata;
endmodule

// *** test/bar_master_properties.sv ***
`timescale 1ns/1ns
// relocation checker
module bar_master_properties (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        cpu_req,
    input wire logic        cpu_byte,
    input wire logic        bus_master,
    input wire logic        bus_valid,
    input wire logic        align_err,
    input wire logic [15:0] cpu_addr,
    input wire logic [17:0] bus_addr,
    input wire logic [1:0]  bus_be
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire acc = cpu_req && bus_master;
    wire ok = acc && (cpu_byte || !cpu_addr[0]);
    top_force_a: assert property (ok && &cpu_addr[15:13] |=>
        bus_valid && bus_addr == {2'h3, $past(cpu_addr)}) else $error("top");
    low_pass_a: assert property (ok && !cpu_addr[13] |=>
        bus_valid && bus_addr == {2'h0, $past(cpu_addr)}) else $error("low");
    odd_word_a: assert property (acc && !cpu_byte && cpu_addr[0] |=>
        align_err && !bus_valid) else $error("odd word");
    byte_lane_a: assert property (ok && cpu_byte |=>
        bus_be == ($past(cpu_addr[0]) ? 2'h2 : 2'h1)) else $error("lane");
    master_off_a: assert property (!bus_master |=>
        !bus_valid && !align_err) else $error("not master");
    word_lane_a: assert property (ok && !cpu_byte |=>
        bus_be == 2'h3) else $error("word lane");
    addr_hold_a: assert property (!ok |=>
        $stable(bus_addr)) else $error("addr hold");
    cover property (bus_valid && bus_addr[17:16] == 2'h3);
    cover property (align_err);
    cover property (bus_valid && bus_be == 2'h2);
    cover property (cpu_req && !bus_master);
endmodule
bind bar_master bar_master_properties u_bar_master_properties (
    .core_clk   (core_clk),
    .rst        (rst),
    .cpu_req    (cpu_req),
    .cpu_byte   (cpu_byte),
    .bus_master (bus_master),
    .bus_valid  (bus_valid),
    .align_err  (align_err),
    .cpu_addr   (cpu_addr),
    .bus_addr   (bus_addr),
    .bus_be     (bus_be)
);

// *** test/bar_mem_model.sv ***
`timescale 1ns/1ns
// word memory on the far side of the bus
module bar_mem_model (
    input wire logic        core_clk,
    input wire logic        bus_valid,
    input wire logic        bus_write,
    input wire logic [17:0] bus_addr,
    input wire logic [1:0]  bus_be,
    input wire logic [15:0] bus_wdata
);
    logic [15:0] mem [256];
    // strobed lanes of an even word; top 8k holds no memory
    always @(posedge core_clk) for (int i = 0; i < 2; i++)
        if (bus_valid && bus_write && bus_be[i] && bus_addr[17:13] != 5'h1F)
            mem[bus_addr[8:1]][8*i+:8] <= bus_wdata[8*i+:8];
endmodule

// *** test/bar_master_tb.sv ***
`timescale 1ns/1ns
// relocation bench
module bar_master_tb;
    logic core_clk = 0, rst = 1, cpu_req = 0, cpu_write = 0, cpu_byte = 0;
    logic bus_master = 1, bus_valid, bus_write, align_err;
    logic [15:0] cpu_addr = 16'h0, cpu_wdata = 16'h0, bus_wdata;
    logic [17:0] bus_addr;
    logic [1:0] bus_be;
    int n_errors = 0, samples_checked = 0;
    bar_master u_bar_master (
        .core_clk   (core_clk),
        .rst        (rst),
        .cpu_req    (cpu_req),
        .cpu_addr   (cpu_addr),
        .cpu_write  (cpu_write),
        .cpu_byte   (cpu_byte),
        .cpu_wdata  (cpu_wdata),
        .bus_master (bus_master),
        .bus_valid  (bus_valid),
        .bus_addr   (bus_addr),
        .bus_write  (bus_write),
        .bus_be     (bus_be),
        .bus_wdata  (bus_wdata),
        .align_err  (align_err)
    );
    bar_mem_model u_bar_mem_model (
        .core_clk  (core_clk),
        .bus_valid (bus_valid),
        .bus_write (bus_write),
        .bus_addr  (bus_addr),
        .bus_be    (bus_be),
        .bus_wdata (bus_wdata)
    );
    initial forever #10 core_clk = ~core_clk;
    task automatic chk(logic [19:0] g, e);
        samples_checked++;
        n_errors += int'(g !== e);
        if (g !== e) $display("wrong value %0t %h %h", $time, g, e);
    endtask
    task automatic go(logic [15:0] a, d, logic w, b);
        @(posedge core_clk) {cpu_req, cpu_addr, cpu_wdata, cpu_write,
            cpu_byte} <= {1'b1, a, d, w, b};
        @(posedge core_clk) cpu_req <= 0;
        @(negedge core_clk);
    endtask
    task automatic t_reloc;
        logic [15:0] a [4] = '{16'h0, 16'hDFFE, 16'hE000, 16'hFFFE};
        foreach (a[i]) begin
            go(a[i], 16'h0, 0, 0);
            chk(bus_addr, {{2{&a[i][15:13]}}, a[i]});
            chk(bus_valid, 1'h1);
        end
        $display("reloc done");
    endtask
    task automatic t_lane;
        go(16'h10, 16'h1234, 1, 0);
        chk({bus_write, bus_be}, 3'h7);
        chk(bus_wdata, 16'h1234);
        go(16'h12, 16'h5678, 1, 0);
        go(16'h12, 16'h00CD, 1, 1);
        chk({bus_valid, bus_be}, 3'h5);
        go(16'h11, 16'hAB, 1, 1);
        chk({bus_be, bus_wdata}, 18'h2ABAB);
        go(16'h13, 16'h0, 0, 0);
        // refused odd word leaves the byte lane standing
        chk({align_err, bus_valid, bus_be}, 4'hA);
        chk(u_bar_mem_model.mem[8], 16'hAB34);
        chk(u_bar_mem_model.mem[9], 16'h56CD);
        $display("lane done");
    endtask
    task automatic t_master;
        @(posedge core_clk) bus_master <= 1'h0;
        go(16'hE000, 16'h0, 1, 0);
        // request without bus ownership leaves everything standing
        chk({align_err, bus_valid}, 2'h0);
        chk(bus_addr, 18'h00011);
        go(16'h13, 16'h0, 0, 0);
        chk(align_err, 1'h0);
        @(posedge core_clk) bus_master <= 1'h1;
        go(16'hE002, 16'h0, 0, 0);
        chk(bus_addr, 18'h3E002);
        chk({bus_valid, bus_write, bus_be}, 4'hB);
        $display("master done");
    endtask
    task automatic tally_and_finish;
        $display("checked %0d wrong %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 0;
        t_reloc;
        t_lane;
        t_master;
        tally_and_finish;
    end
endmodule
